// ### core/wdti_pkg.sv
package wdti_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_FREQ_KHZ = 50000;
    localparam int unsigned OSC_FREQ_KHZ = 128;
    // Oscillator must stay well below the system clock for edge sampling
    localparam int unsigned OSC_RATIO = CLK_FREQ_KHZ / OSC_FREQ_KHZ;
    localparam logic [2:0] CE_WINDOW_CYCLES = 3'h4;

    // ************************************************************
    // Period selection
    // ************************************************************
    localparam int unsigned CNT_W = 20;
    localparam logic [20:0] PERIOD_BASE_CYCLES = 21'h000800;
    localparam logic [3:0] PERIOD_CODE_MAX = 4'h9;

    // ************************************************************
    // Control/status register layout
    // ************************************************************
    localparam int unsigned BIT_IRQ_FLAG = 7;
    localparam int unsigned BIT_IRQ_EN = 6;
    localparam int unsigned BIT_PSEL_MSB = 5;
    localparam int unsigned BIT_CHANGE_EN = 4;
    localparam int unsigned BIT_WD_EN = 3;
    localparam int unsigned BIT_PSEL_BIT2 = 2;
    localparam int unsigned BIT_PSEL_BIT1 = 1;
    localparam int unsigned BIT_PSEL_BIT0 = 0;

    // ************************************************************
    // State types
    // ************************************************************
    typedef struct packed {
        logic timeout_irq_flag;
        logic timeout_irq_enable;
        logic [3:0] period_select;
        logic change_enable;
        logic [2:0] ce_count;
        logic watchdog_enable;
        logic watchdog_reset_flag;
        logic reset_req;
    } wdti_ctrl_t;

    localparam wdti_ctrl_t CTRL_RST = '{
        timeout_irq_flag: 1'b0,
        timeout_irq_enable: 1'b0,
        period_select: 4'h0,
        change_enable: 1'b0,
        ce_count: 3'h0,
        watchdog_enable: 1'b0,
        watchdog_reset_flag: 1'b0,
        reset_req: 1'b0
    };

    typedef struct packed {
        logic osc_meta;
        logic osc_stage;
        logic osc_prev;
        logic fuse_meta;
        logic fuse_stage;
        logic tick;
    } wdti_sync_t;

    localparam wdti_sync_t SYNC_RST = '{
        osc_meta: 1'b0,
        osc_stage: 1'b0,
        osc_prev: 1'b0,
        fuse_meta: 1'b0,
        fuse_stage: 1'b0,
        tick: 1'b0
    };

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic timeout;
    } wdti_cnt_t;

    localparam wdti_cnt_t CNT_RST = '{
        count: 20'h00000,
        timeout: 1'b0
    };

endpackage : wdti_pkg

// ### core/wdti_sync.sv
`timescale 1ns/100ps
module wdti_sync (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Asynchronous sources
    input wire logic osc_128k_i,
    input wire logic safety_level_fuse_i,
    // Synchronised results
    output logic osc_tick_o,
    output logic level2_o
);

    wdti_pkg::wdti_sync_t q;
    wdti_pkg::wdti_sync_t d;

    // ************************************************************
    // Two-stage capture, edge detect on the second stage only
    // ************************************************************
    always_comb begin
        d = q;
        d.osc_meta = osc_128k_i;
        d.osc_stage = q.osc_meta;
        d.osc_prev = q.osc_stage;
        d.fuse_meta = safety_level_fuse_i;
        d.fuse_stage = q.fuse_meta;
        d.tick = q.osc_stage & ~q.osc_prev;
        if (srst_i) begin
            d = wdti_pkg::SYNC_RST;
            // Fuse is static, so its capture keeps running through reset
            d.fuse_meta = safety_level_fuse_i;
            d.fuse_stage = q.fuse_meta;
        end
    end

    always_ff @(posedge clk_i) begin
        q <= d;
    end

    assign osc_tick_o = q.tick;
    assign level2_o = q.fuse_stage;

endmodule : wdti_sync

// ### core/wdti_counter.sv
`timescale 1ns/100ps
module wdti_counter (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Control
    input wire logic tick_i,
    input wire logic clear_i,
    input wire logic [3:0] period_select_i,
    // Event
    output logic timeout_o
);

    wdti_pkg::wdti_cnt_t q;
    wdti_pkg::wdti_cnt_t d;
    logic [3:0] code;
    logic [20:0] span;
    logic [wdti_pkg::CNT_W-1:0] limit;

    // ************************************************************
    // Oscillator cycle counter
    // ************************************************************
    always_comb begin
        // Reserved codes fall back to the longest valid period
        code = (period_select_i > wdti_pkg::PERIOD_CODE_MAX) ?
            wdti_pkg::PERIOD_CODE_MAX : period_select_i;
        span = wdti_pkg::PERIOD_BASE_CYCLES << code;
        limit = wdti_pkg::CNT_W'(span - 21'h000001);
        d = q;
        d.timeout = 1'b0;
        if (tick_i) begin
            if (q.count >= limit) begin
                d.count = '0;
                d.timeout = 1'b1;
            end else begin
                d.count = q.count + 20'h00001;
            end
        end
        // Clear wins over a tick arriving in the same cycle
        if (clear_i || srst_i) begin
            d = wdti_pkg::CNT_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        q <= d;
    end

    assign timeout_o = q.timeout;

endmodule : wdti_counter

// ### core/wdti_top.sv
`timescale 1ns/100ps
module wdti_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic por_i,
    // Watchdog oscillator and fuse
    input wire logic osc_128k_i,
    input wire logic safety_level_fuse_i,
    // CPU core register port
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // CPU core events
    input wire logic counter_clear_i,
    input wire logic global_irq_enable_i,
    input wire logic irq_ack_i,
    output logic irq_o,
    // Reset generator and cause register
    input wire logic reset_flag_clear_i,
    output logic reset_req_o,
    output logic watchdog_reset_flag_o
);

    wdti_pkg::wdti_ctrl_t q;
    wdti_pkg::wdti_ctrl_t d;
    logic osc_tick;
    logic level2;
    logic timeout;
    logic running;
    logic cnt_clear;
    logic wr_open;

    // ************************************************************
    // Oscillator and fuse capture
    // ************************************************************
    wdti_sync u_sync (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .osc_128k_i(osc_128k_i),
        .safety_level_fuse_i(safety_level_fuse_i),
        .osc_tick_o(osc_tick),
        .level2_o(level2)
    );

    // ************************************************************
    // Time-out counter
    // ************************************************************
    assign running = q.watchdog_enable | q.timeout_irq_enable;
    assign cnt_clear = counter_clear_i | ~running;

    wdti_counter u_counter (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .tick_i(osc_tick),
        .clear_i(cnt_clear),
        .period_select_i(q.period_select),
        .timeout_o(timeout)
    );

    // ************************************************************
    // Control state
    // ************************************************************
    // Opening the window takes change-enable and enable in one write
    assign wr_open = reg_wdata_i[wdti_pkg::BIT_CHANGE_EN] & reg_wdata_i[wdti_pkg::BIT_WD_EN];

    always_comb begin
        d = q;
        d.reset_req = 1'b0;
        // Window timer in system clock cycles
        if (q.change_enable) begin
            if (q.ce_count == wdti_pkg::CE_WINDOW_CYCLES - 3'h1) begin
                d.change_enable = 1'b0;
                d.ce_count = 3'h0;
            end else begin
                d.ce_count = q.ce_count + 3'h1;
            end
        end
        if (reg_wr_i) begin
            d.timeout_irq_enable = reg_wdata_i[wdti_pkg::BIT_IRQ_EN];
            if (wr_open) begin
                d.change_enable = 1'b1;
                d.ce_count = 3'h0;
            end else begin
                // Any other write consumes an open window
                d.change_enable = 1'b0;
                d.ce_count = 3'h0;
            end
            if (reg_wdata_i[wdti_pkg::BIT_WD_EN]) begin
                d.watchdog_enable = 1'b1;
            end else if (q.change_enable) begin
                d.watchdog_enable = 1'b0;
            end
            if (!level2 || q.change_enable) begin
                d.period_select = {reg_wdata_i[wdti_pkg::BIT_PSEL_MSB],
                    reg_wdata_i[wdti_pkg::BIT_PSEL_BIT2],
                    reg_wdata_i[wdti_pkg::BIT_PSEL_BIT1],
                    reg_wdata_i[wdti_pkg::BIT_PSEL_BIT0]};
            end
            if (reg_wdata_i[wdti_pkg::BIT_IRQ_FLAG]) begin
                d.timeout_irq_flag = 1'b0;
            end
        end
        if (irq_ack_i) begin
            d.timeout_irq_flag = 1'b0;
        end
        // Time-out action; set placed last so it beats any clear
        if (timeout) begin
            if (q.timeout_irq_enable) begin
                d.timeout_irq_flag = 1'b1;
                if (q.watchdog_enable) begin
                    d.timeout_irq_enable = 1'b0;
                end
            end else if (q.watchdog_enable) begin
                d.reset_req = 1'b1;
            end
        end
        d.watchdog_reset_flag = (q.watchdog_reset_flag & ~reset_flag_clear_i) |
            d.reset_req;
        if (por_i) begin
            d.watchdog_reset_flag = 1'b0;
        end
        // Stored value is the forced one, so reads come from flops
        if (level2) begin
            d.watchdog_enable = 1'b1;
        end
        if (d.watchdog_reset_flag && !level2) begin
            d.watchdog_enable = 1'b1;
        end
        if (srst_i) begin
            d = wdti_pkg::CTRL_RST;
            // Flag survives the chip reset it caused
            d.watchdog_reset_flag = por_i ? 1'b0 : q.watchdog_reset_flag;
            // Enable stays forced through the chip reset itself
            d.watchdog_enable = d.watchdog_reset_flag | level2;
        end
    end

    always_ff @(posedge clk_i) begin
        q <= d;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    always_comb begin
        reg_rdata_o = 8'h00;
        reg_rdata_o[wdti_pkg::BIT_IRQ_FLAG] = q.timeout_irq_flag;
        reg_rdata_o[wdti_pkg::BIT_IRQ_EN] = q.timeout_irq_enable;
        reg_rdata_o[wdti_pkg::BIT_PSEL_MSB] = q.period_select[3];
        reg_rdata_o[wdti_pkg::BIT_CHANGE_EN] = q.change_enable;
        reg_rdata_o[wdti_pkg::BIT_WD_EN] = q.watchdog_enable;
        reg_rdata_o[wdti_pkg::BIT_PSEL_BIT2] = q.period_select[2];
        reg_rdata_o[wdti_pkg::BIT_PSEL_BIT1] = q.period_select[1];
        reg_rdata_o[wdti_pkg::BIT_PSEL_BIT0] = q.period_select[0];
    end

    assign irq_o = q.timeout_irq_flag & q.timeout_irq_enable & global_irq_enable_i;
    assign reset_req_o = q.reset_req;
    assign watchdog_reset_flag_o = q.watchdog_reset_flag;

endmodule : wdti_top

// ### bench/wdti_chk.sv
`timescale 1ns/100ps
module wdti_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Watched inputs
    input wire logic safety_level_fuse_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic global_irq_enable_i,
    input wire logic reset_flag_clear_i,
    // Watched outputs
    input wire logic [7:0] reg_rdata_o,
    input wire logic irq_o,
    input wire logic reset_req_o,
    input wire logic watchdog_reset_flag_o
);
    // ********
    // Checks
    // ********
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    logic open_w;
    assign open_w = reg_wr_i && reg_wdata_i[4] && reg_wdata_i[3];
    a_req_pulse: assert property (reset_req_o |=> !reset_req_o)
        else $error("reset request too long");
    a_req_flag: assert property (reset_req_o |-> watchdog_reset_flag_o)
        else $error("reset flag not set");
    a_req_mode: assert property (reset_req_o |->
        $past(reg_rdata_o[3]) && !$past(reg_rdata_o[6])) else $error("reset in wrong mode");
    a_irq_gate: assert property (irq_o ==
        (reg_rdata_o[7] && reg_rdata_o[6] && global_irq_enable_i)) else $error("irq gating");
    a_ce_open: assert property (open_w ##1 (!reg_wr_i)[*4] |-> reg_rdata_o[4])
        else $error("window closed early");
    a_ce_close: assert property (open_w ##1 (!reg_wr_i)[*6] |-> !reg_rdata_o[4])
        else $error("window stays open");
    a_lvl2_en: assert property (safety_level_fuse_i[*8] |-> reg_rdata_o[3])
        else $error("level two enable low");
    a_rflag_en: assert property (watchdog_reset_flag_o[*3] |-> reg_rdata_o[3])
        else $error("flag does not force enable");
    a_w1c_flag: assert property (reg_wr_i && reg_wdata_i[7] |=> !reg_rdata_o[7])
        else $error("flag not cleared by write");
    a_no_window: assert property (reg_wr_i && !reg_wdata_i[3] &&
        !reg_rdata_o[4] && reg_rdata_o[3] |=> reg_rdata_o[3]) else $error("enable cleared");
    a_rflag_clr: assert property (reset_flag_clear_i |=>
        !watchdog_reset_flag_o || reset_req_o) else $error("reset flag not cleared");
    c_req: cover property (reset_req_o);
    c_irq: cover property (irq_o);
    c_seq: cover property (open_w ##2 (reg_wr_i && !reg_wdata_i[3]));
endmodule : wdti_chk

// ### bench/wdti_cpu_model.sv
`timescale 1ns/100ps
module wdti_cpu_model (
    // Clock
    input wire logic clk_i,
    // Register port and events
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    output logic counter_clear_o,
    output logic irq_ack_o,
    output logic reset_flag_clear_o
);
    // ********
    // Core side
    // ********
    initial begin
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
        {reset_flag_clear_o, irq_ack_o, counter_clear_o} = 3'h0;
    end
    // Idle data inverted so a stale byte never looks valid
    task automatic write(input logic [7:0] d);
        @(posedge clk_i);
        #1;
        reg_wr_o = 1'b1;
        reg_wdata_o = d;
        @(posedge clk_i);
        #1;
        reg_wr_o = 1'b0;
        reg_wdata_o = ~d;
    endtask : write
    // Bit 0 clear counter, bit 1 vector taken, bit 2 clear reset flag
    task automatic pulse(input logic [2:0] e);
        @(posedge clk_i);
        #1;
        {reset_flag_clear_o, irq_ack_o, counter_clear_o} = e;
        @(posedge clk_i);
        #1;
        {reset_flag_clear_o, irq_ack_o, counter_clear_o} = 3'h0;
    endtask : pulse
endmodule : wdti_cpu_model

// ### bench/test_wdti_top.sv
`timescale 1ns/100ps
module test_wdti_top;
    logic clk_i, srst_i, por_i, osc_128k_i, safety_level_fuse_i, global_irq_enable_i;
    logic reg_wr_i, counter_clear_i, irq_ack_i, reset_flag_clear_i;
    logic irq_o, reset_req_o, watchdog_reset_flag_o;
    logic [7:0] reg_wdata_i;
    logic [7:0] reg_rdata_o;
    int failures, checks, n;
    // ********
    // Clocks and parts
    // ********
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // Fast oscillator, 8 clocks a tick, keeps the shortest period near 16K clocks
    initial begin
        osc_128k_i = 1'b0;
        forever #80 osc_128k_i = ~osc_128k_i;
    end
    wdti_cpu_model cpu (.clk_i(clk_i), .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i),
        .counter_clear_o(counter_clear_i), .irq_ack_o(irq_ack_i),
        .reset_flag_clear_o(reset_flag_clear_i));
    wdti_top uut (.clk_i(clk_i), .srst_i(srst_i), .por_i(por_i), .osc_128k_i(osc_128k_i),
        .safety_level_fuse_i(safety_level_fuse_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .counter_clear_i(counter_clear_i), .global_irq_enable_i(global_irq_enable_i),
        .irq_ack_i(irq_ack_i), .irq_o(irq_o), .reset_flag_clear_i(reset_flag_clear_i),
        .reset_req_o(reset_req_o), .watchdog_reset_flag_o(watchdog_reset_flag_o));
    // ********
    // Tasks
    // ********
    task automatic end_of_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
        checks++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk8
    task automatic chk1(input string nm, input logic e, input logic s);
        chk8(nm, {7'h00, e}, {7'h00, s});
    endtask : chk1
    // Cycle count window: 2048 ticks of 8 clocks plus sync and phase slack
    task automatic chk_n(input string nm, input int s);
        checks++;
        if (s < 16370 || s > 16400) begin
            failures++;
            $display("mismatch %s expected 16370..16400 seen %0d", nm, s);
        end
    endtask : chk_n
    task automatic tick(input int k);
        repeat (k) begin
            @(posedge clk_i);
            #1;
        end
    endtask : tick
    task automatic wait_hi(input logic sel, output int cnt);
        cnt = 0;
        while ((sel ? reset_req_o : reg_rdata_o[7]) !== 1'b1) begin
            tick(1);
            cnt++;
            if (cnt > 20000) begin
                failures++;
                $display("mismatch wait expected event seen none");
                end_of_test();
            end
        end
    endtask : wait_hi
    // ********
    // Sequence
    // ********
    initial begin
        srst_i = 1'b1;
        por_i = 1'b1;
        safety_level_fuse_i = 1'b0;
        global_irq_enable_i = 1'b0;
        failures = 0;
        checks = 0;
        repeat (4) @(posedge clk_i);
        #1;
        srst_i = 1'b0;
        por_i = 1'b0;
        tick(4);
        chk8("reset", 8'h00, reg_rdata_o);
        chk1("rflag", 1'b0, watchdog_reset_flag_o);
        $display("test reset done");
        global_irq_enable_i = 1'b1;
        cpu.write(8'h40);
        wait_hi(1'b0, n);
        chk_n("irq_period", n);
        chk1("irq", 1'b1, irq_o);
        global_irq_enable_i = 1'b0;
        tick(1);
        chk1("irq_masked", 1'b0, irq_o);
        cpu.pulse(3'h2);
        chk8("ack", 8'h40, reg_rdata_o);
        tick(4000);
        cpu.pulse(3'h1);
        cpu.write(8'h48);
        wait_hi(1'b0, n);
        chk_n("clear", n);
        chk8("both", 8'h88, reg_rdata_o);
        $display("test interrupt done");
        cpu.pulse(3'h1);
        cpu.write(8'h88);
        chk8("w1c", 8'h08, reg_rdata_o);
        wait_hi(1'b1, n);
        chk_n("reset_period", n);
        chk1("rflag_set", 1'b1, watchdog_reset_flag_o);
        cpu.write(8'h18);
        cpu.write(8'h00);
        chk8("forced", 8'h08, reg_rdata_o);
        // Chip reset in mid-run keeps the flag and the forced enable
        srst_i = 1'b1;
        tick(2);
        chk8("rst_forced", 8'h08, reg_rdata_o);
        srst_i = 1'b0;
        tick(2);
        chk1("rflag_kept", 1'b1, watchdog_reset_flag_o);
        chk8("rst_release", 8'h08, reg_rdata_o);
        chk1("rst_req", 1'b0, reset_req_o);
        $display("test chip reset done");
        cpu.pulse(3'h4);
        chk1("rflag_clr", 1'b0, watchdog_reset_flag_o);
        cpu.write(8'h00);
        chk8("no_window", 8'h08, reg_rdata_o);
        cpu.write(8'h18);
        chk1("ce_set", 1'b1, reg_rdata_o[4]);
        tick(6);
        chk8("ce_auto", 8'h08, reg_rdata_o);
        cpu.pulse(3'h1);
        wait_hi(1'b1, n);
        chk_n("reset_again", n);
        por_i = 1'b1;
        tick(1);
        por_i = 1'b0;
        chk1("por_clr", 1'b0, watchdog_reset_flag_o);
        cpu.write(8'h18);
        cpu.write(8'h00);
        chk8("disabled", 8'h00, reg_rdata_o);
        $display("test level one done");
        safety_level_fuse_i = 1'b1;
        tick(6);
        chk8("lvl2_on", 8'h08, reg_rdata_o);
        cpu.write(8'h18);
        cpu.write(8'h00);
        chk8("lvl2_keep", 8'h08, reg_rdata_o);
        cpu.write(8'h01);
        chk8("lvl2_period", 8'h08, reg_rdata_o);
        cpu.write(8'h18);
        cpu.write(8'h05);
        chk8("lvl2_change", 8'h0D, reg_rdata_o);
        $display("test level two done");
        end_of_test();
    end
endmodule : test_wdti_top
bind wdti_top wdti_chk chk (.clk_i(clk_i), .srst_i(srst_i),
    .safety_level_fuse_i(safety_level_fuse_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .global_irq_enable_i(global_irq_enable_i),
    .reset_flag_clear_i(reset_flag_clear_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
    .reset_req_o(reset_req_o), .watchdog_reset_flag_o(watchdog_reset_flag_o));
